// [logic/rei_pkg.sv]
package rei_pkg;
	// Fixed device address of the general map (8-bit write form)
	localparam logic [7:0] I2C_ADDR_WR = 8'h98;
	localparam logic [6:0] I2C_ADDR = I2C_ADDR_WR[7:1];

	// Register offsets within the map
	localparam logic [7:0] OFS_STATUS_TWO = 8'h7F;
	localparam logic [7:0] OFS_CLEAR_TWO = 8'h80;
	localparam logic [7:0] OFS_MASK_TWO = 8'h81;
	localparam logic [7:0] OFS_STATUS_THREE = 8'h84;
	localparam logic [7:0] OFS_CLEAR_THREE = 8'h85;
	localparam logic [7:0] OFS_MASK_THREE = 8'h86;

	// Flag vector layout: register two in the low bits, three above
	localparam int N_FLAGS = 12;
	localparam int TWO_BITS = 4;
	localparam int THREE_BASE = 4;
	localparam int BIT_ACR_N = 3;
	localparam int BIT_HDR_ERR = 2;
	localparam int BIT_AUD_ERR = 1;
	localparam int BIT_GAMUT = 0;
	localparam int BIT_DEPTH = 7;
	localparam int BIT_LCLK_IRR = 6;
	localparam int BIT_AUD_KIND = 5;
	localparam int BIT_PARITY = 4;
	localparam int BIT_RATE = 3;
	localparam int BIT_FLAT = 2;
	localparam int BIT_FREQ = 1;
	localparam int BIT_BUF_LOW = 0;

	// Reset values and byte framing
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [11:0] FLAGS_RESET = 12'h000;
	localparam logic [11:0] MASK_RESET = 12'h000;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Serial port protocol states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_AACK = 4'h2,
		ST_SUB = 4'h3,
		ST_SACK = 4'h4,
		ST_WR = 4'h5,
		ST_WACK = 4'h6,
		ST_RD = 4'h7,
		ST_RACK = 4'h8
	} rei_state_t;

	// Single-cycle event pulses from the receiver's detectors
	typedef struct packed {
		logic acr_divisor_changed;
		logic header_uncorrectable;
		logic audio_pkt_uncorrectable;
		logic gamut_metadata_new;
		logic colour_depth_change;
		logic link_clock_irregular;
		logic audio_kind_change;
		logic audio_parity_fault;
		logic sample_rate_change;
		logic flatline_audio;
		logic link_freq_change;
		logic audio_buffer_low;
	} rei_evt_t;

	// Two-wire port input levels
	typedef struct packed {
		logic scl;
		logic sda;
	} rei_pins_t;
endpackage : rei_pkg

// [logic/rei_edge_irq_status.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - A set flag stays high until software writes its paired clear bit.
// - A flag only counts toward the interrupt while its mask bit is set.
// - Status registers are read-only; writes there never alter any flag.
// - Bit 3 of status two sets when the clock regeneration N value changes.
// - Bit 2 of status two sets on uncorrectable unknown-packet header error.
// - Bit 1 of status two sets on an uncorrectable audio packet error.
// - Bit 0 of status two sets when a new gamut metadata packet arrives.
// - Bit 7 of status three sets when the deep colour mode changes.
// - Bit 6 of status three sets on irregular or missing link clock pulses.
// - Bit 5 of status three sets whenever the audio mode changes.
// - Bit 4 of status three sets on an audio packet parity error.
// - Bit 3 of status three sets when channel zero sample-rate bits change.
// - Bit 2 of status three sets on audio samples with flat-line set.
// - Bit 1 of status three sets when link frequency leaves tolerance.
// - Bit 0 of status three sets when audio buffer reaches low threshold.
// - Registers are reached over the two-wire port at the fixed address.
module rei_edge_irq_status #(
	parameter logic [6:0] DEV_ADDR = rei_pkg::I2C_ADDR
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// Two-wire register port
	input wire rei_pkg::rei_pins_t i_bus,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// Detector events
	input wire rei_pkg::rei_evt_t i_evt,
	// Latched flags and interrupt
	output logic [rei_pkg::N_FLAGS-1:0] o_flags,
	output logic o_first_irq_output
);

	////////////////////////////////////////////////////////////////////////////
	// Reserved two-wire addresses cannot be served
	generate
		if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
			$error("Device address lies in a reserved range");
		end
	endgenerate

	// Places a byte into the flag vector lanes of the register pair
	function automatic logic [rei_pkg::N_FLAGS-1:0] lanes(
		input logic [7:0] ofs,
		input logic [7:0] data,
		input logic [7:0] ofs_two,
		input logic [7:0] ofs_three
	);
		logic [rei_pkg::N_FLAGS-1:0] v;
		v = '0;
		if (ofs == ofs_two) begin
			v[rei_pkg::TWO_BITS-1:0] = data[rei_pkg::TWO_BITS-1:0];
		end else if (ofs == ofs_three) begin
			v[rei_pkg::N_FLAGS-1:rei_pkg::THREE_BASE] = data;
		end
		return v;
	endfunction : lanes

	////////////////////////////////////////////////////////////////////////////
	// Signals
	rei_pkg::rei_pins_t prev;
	rei_pkg::rei_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] sub;
	logic [7:0] rd_now;
	logic rw;
	logic acked;
	logic wr_stb;
	logic [7:0] wr_sub;
	logic [7:0] wr_data;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic [rei_pkg::N_FLAGS-1:0] flags;
	logic [rei_pkg::N_FLAGS-1:0] mask;
	logic [rei_pkg::N_FLAGS-1:0] clr;
	logic [rei_pkg::N_FLAGS-1:0] evt;
	logic [rei_pkg::N_FLAGS-1:0] wr_lane;
	logic [rei_pkg::N_FLAGS-1:0] wr_bits;

	////////////////////////////////////////////////////////////////////////////
	// Event pulses mapped onto register bit positions
	assign evt[rei_pkg::BIT_ACR_N] = i_evt.acr_divisor_changed;
	assign evt[rei_pkg::BIT_HDR_ERR] = i_evt.header_uncorrectable;
	assign evt[rei_pkg::BIT_AUD_ERR] = i_evt.audio_pkt_uncorrectable;
	assign evt[rei_pkg::BIT_GAMUT] = i_evt.gamut_metadata_new;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_DEPTH] =
		i_evt.colour_depth_change;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_LCLK_IRR] =
		i_evt.link_clock_irregular;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_AUD_KIND] =
		i_evt.audio_kind_change;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_PARITY] =
		i_evt.audio_parity_fault;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_RATE] =
		i_evt.sample_rate_change;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_FLAT] =
		i_evt.flatline_audio;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_FREQ] =
		i_evt.link_freq_change;
	assign evt[rei_pkg::THREE_BASE+rei_pkg::BIT_BUF_LOW] =
		i_evt.audio_buffer_low;

	////////////////////////////////////////////////////////////////////////////
	// Bus edges; pins are synchronous so one stored copy suffices
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			prev <= '1;
		end else if (i_ce) begin
			prev <= i_bus;
		end
	end

	assign scl_rise = i_bus.scl & ~prev.scl;
	assign scl_fall = ~i_bus.scl & prev.scl;
	assign start = prev.sda & ~i_bus.sda & i_bus.scl & prev.scl;
	assign stop = ~prev.sda & i_bus.sda & i_bus.scl & prev.scl;
	assign o_sda_out = 1'b0; // Open drain: only ever pulls low

	// Read mux; clear registers read zero, status bits above width too
	always_comb begin
		rd_now = rei_pkg::BYTE_ZERO;
		case (sub)
			rei_pkg::OFS_STATUS_TWO: begin
				rd_now[rei_pkg::TWO_BITS-1:0] = flags[rei_pkg::TWO_BITS-1:0];
			end
			rei_pkg::OFS_STATUS_THREE: begin
				rd_now = flags[rei_pkg::N_FLAGS-1:rei_pkg::THREE_BASE];
			end
			rei_pkg::OFS_MASK_TWO: begin
				rd_now[rei_pkg::TWO_BITS-1:0] = mask[rei_pkg::TWO_BITS-1:0];
			end
			rei_pkg::OFS_MASK_THREE: begin
				rd_now = mask[rei_pkg::N_FLAGS-1:rei_pkg::THREE_BASE];
			end
			default: begin
				rd_now = rei_pkg::BYTE_ZERO;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-wire slave; no clock stretching, subaddress auto-increments
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			state <= rei_pkg::ST_IDLE;
			bit_cnt <= '0;
			shift <= rei_pkg::BYTE_ZERO;
			sub <= rei_pkg::BYTE_ZERO;
			rw <= 1'b0;
			acked <= 1'b0;
			o_sda_oe_n <= 1'b1;
			wr_stb <= 1'b0;
			wr_sub <= rei_pkg::BYTE_ZERO;
			wr_data <= rei_pkg::BYTE_ZERO;
		end else if (i_ce) begin
			wr_stb <= 1'b0;
			if (start) begin
				state <= rei_pkg::ST_ADDR;
				bit_cnt <= '0;
				o_sda_oe_n <= 1'b1;
			end else if (stop) begin
				state <= rei_pkg::ST_IDLE;
				o_sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					rei_pkg::ST_ADDR, rei_pkg::ST_SUB, rei_pkg::ST_WR: begin
						shift <= {shift[6:0], i_bus.sda};
						bit_cnt <= bit_cnt + 4'h1;
					end
					rei_pkg::ST_RACK: begin
						acked <= ~i_bus.sda;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					rei_pkg::ST_ADDR: begin
						if (bit_cnt == rei_pkg::BYTE_BITS) begin
							// Other addresses are left alone until the next start
							if (shift[7:1] == DEV_ADDR) begin
								state <= rei_pkg::ST_AACK;
								rw <= shift[0];
								o_sda_oe_n <= 1'b0;
							end else begin
								state <= rei_pkg::ST_IDLE;
							end
						end
					end
					rei_pkg::ST_AACK, rei_pkg::ST_RACK: begin
						if (state == rei_pkg::ST_AACK && !rw) begin
							state <= rei_pkg::ST_SUB;
							bit_cnt <= '0;
							o_sda_oe_n <= 1'b1;
						end else if (state == rei_pkg::ST_AACK || acked) begin
							// Load a byte and drive its top bit at once
							state <= rei_pkg::ST_RD;
							o_sda_oe_n <= rd_now[7];
							shift <= {rd_now[6:0], 1'b0};
							bit_cnt <= 4'h1;
							sub <= sub + 8'h01;
						end else begin
							state <= rei_pkg::ST_IDLE;
							o_sda_oe_n <= 1'b1;
						end
					end
					rei_pkg::ST_SUB: begin
						if (bit_cnt == rei_pkg::BYTE_BITS) begin
							state <= rei_pkg::ST_SACK;
							sub <= shift;
							o_sda_oe_n <= 1'b0;
						end
					end
					rei_pkg::ST_SACK, rei_pkg::ST_WACK: begin
						state <= rei_pkg::ST_WR;
						bit_cnt <= '0;
						o_sda_oe_n <= 1'b1;
					end
					rei_pkg::ST_WR: begin
						if (bit_cnt == rei_pkg::BYTE_BITS) begin
							state <= rei_pkg::ST_WACK;
							o_sda_oe_n <= 1'b0;
							wr_stb <= 1'b1;
							wr_sub <= sub;
							wr_data <= shift;
							sub <= sub + 8'h01;
						end
					end
					rei_pkg::ST_RD: begin
						if (bit_cnt == rei_pkg::BYTE_BITS) begin
							state <= rei_pkg::ST_RACK;
							o_sda_oe_n <= 1'b1;
						end else begin
							o_sda_oe_n <= shift[7];
							shift <= {shift[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					default: begin
						state <= rei_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write decode; status offsets have no lanes here, so writes miss them
	assign wr_lane = wr_stb ? lanes(wr_sub, rei_pkg::BYTE_ONES,
		rei_pkg::OFS_MASK_TWO, rei_pkg::OFS_MASK_THREE) : '0;
	assign wr_bits = lanes(wr_sub, wr_data,
		rei_pkg::OFS_MASK_TWO, rei_pkg::OFS_MASK_THREE);
	assign clr = wr_stb ? lanes(wr_sub, wr_data,
		rei_pkg::OFS_CLEAR_TWO, rei_pkg::OFS_CLEAR_THREE) : '0;

	// Mask registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			mask <= rei_pkg::MASK_RESET;
		end else if (i_ce) begin
			mask <= (mask & ~wr_lane) | (wr_bits & wr_lane);
		end
	end

	// Sticky flags; an event in the clear cycle keeps its flag set
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			flags <= rei_pkg::FLAGS_RESET;
		end else if (i_ce) begin
			flags <= evt | (flags & ~clr);
		end
	end

	assign o_flags = flags;

	// Masked-off flags still latch but never raise the output
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_first_irq_output <= 1'b0;
		end else if (i_ce) begin
			o_first_irq_output <= |(flags & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	logic [rei_pkg::N_FLAGS-1:0] keep_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			keep_q <= '0;
		end else begin
			keep_q <= flags & ~(clr & {rei_pkg::N_FLAGS{i_ce}});
		end
	end

	sequence s_addr_done;
		i_ce && !start && !stop && scl_fall && state == rei_pkg::ST_ADDR &&
			bit_cnt == rei_pkg::BYTE_BITS;
	endsequence
	sequence s_status_wr;
		i_ce && wr_stb && (wr_sub == rei_pkg::OFS_STATUS_TWO ||
			wr_sub == rei_pkg::OFS_STATUS_THREE) && evt == '0;
	endsequence

	flag_hold_a: assert property ((flags & keep_q) == keep_q)
		else $error("Flag fell without a clear");
	event_set_a: assert property (i_ce && evt != '0 |=>
		(flags & $past(evt)) == $past(evt))
		else $error("Event did not set its flag");
	clear_done_a: assert property (i_ce && (clr & ~evt) != '0 |=>
		(flags & $past(clr) & ~$past(evt)) == '0)
		else $error("Clear did not drop its flag");
	status_ro_a: assert property (s_status_wr |=>
		flags == $past(flags))
		else $error("Write to status changed a flag");
	irq_follow_a: assert property (i_ce |=>
		o_first_irq_output == |($past(flags) & $past(mask)))
		else $error("Interrupt does not follow enabled flags");
	irq_masked_a: assert property (i_ce && (flags & mask) == '0 ##1
		i_ce && (flags & mask) == '0 |-> !o_first_irq_output)
		else $error("Interrupt raised by a masked flag");
	addr_ack_a: assert property (s_addr_done ##0
		(shift[7:1] == DEV_ADDR) |=> !o_sda_oe_n)
		else $error("Own address not acknowledged");
	addr_miss_a: assert property (s_addr_done ##0
		(shift[7:1] != DEV_ADDR) |=> o_sda_oe_n &&
		state == rei_pkg::ST_IDLE)
		else $error("Foreign address acknowledged");
	read_msb_a: assert property (i_ce && !start && !stop && scl_fall &&
		state == rei_pkg::ST_AACK && rw |=> o_sda_oe_n == $past(rd_now[7]))
		else $error("Read byte top bit not driven");

endmodule : rei_edge_irq_status

// [testbench/tb.sv]
`timescale 1ns/1ps

module tb;
	////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_ce = 1'b1;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	rei_pkg::rei_evt_t evt = '0;
	rei_pkg::rei_pins_t bus;
	logic line;
	logic o_sda_out;
	logic o_sda_oe_n;
	logic [rei_pkg::N_FLAGS-1:0] o_flags;
	logic o_first_irq_output;
	logic [11:0] exp_f = 12'h000;
	logic [7:0] rd;
	int error_cnt = 0;
	int comparisons = 0;

	// Open-drain data line: whoever pulls low wins, otherwise pulled up
	assign line = sda_m & o_sda_oe_n;
	assign bus = rei_pkg::rei_pins_t'({scl, line});

	// Free-running 10 MHz clock
	always #50 i_ref_clk = ~i_ref_clk;

	rei_edge_irq_status i_rei_edge_irq_status (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_bus(bus),
		.o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n),
		.i_evt(evt),
		.o_flags(o_flags),
		.o_first_irq_output(o_first_irq_output)
	);

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic chk_vec(input string nm, input logic [11:0] e,
			input logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_vec

	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	// Event bit k of the struct lands in this flag position
	function automatic logic [11:0] flag_of(input int k);
		if (k >= 8) return 12'h001 << (k - 8);
		return 12'h001 << (k + 4);
	endfunction : flag_of

	////////////////////////////////////////////////////////////////////////
	// Two-wire master; every SCL level is held well over two clocks
	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : cyc

	// Start is cond(1, 0), stop is cond(0, 1): SDA moves while SCL high
	task automatic cond(input logic a, input logic b);
		scl <= 1'b0;
		cyc(2);
		sda_m <= a;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		sda_m <= b;
		cyc(4);
	endtask : cond

	// SDA changes only in the low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		cyc(2);
		sda_m <= b;
		cyc(2);
		scl <= 1'b1;
		cyc(2);
		r = line;
		cyc(2);
	endtask : bit_io

	task automatic byte_tx(input logic [7:0] d, input logic exp_line);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		chk_bit("ack", exp_line, r);
	endtask : byte_tx

	task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
		cond(1'b1, 1'b0);
		byte_tx({rei_pkg::I2C_ADDR, 1'b0}, 1'b0);
		byte_tx(ofs, 1'b0);
		byte_tx(d, 1'b0);
		cond(1'b0, 1'b1);
	endtask : reg_wr

	// Write whose event lands in the very cycle the clear strobe acts
	task automatic wr_race(input logic [7:0] ofs, input logic [7:0] d,
			input logic [11:0] v);
		logic r;
		cond(1'b1, 1'b0);
		byte_tx({rei_pkg::I2C_ADDR, 1'b0}, 1'b0);
		byte_tx(ofs, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		// Fall seen next edge, strobe after it, clear applied one later
		scl <= 1'b0;
		cyc(1);
		evt <= rei_pkg::rei_evt_t'(v);
		cyc(1);
		evt <= '0;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		cond(1'b0, 1'b1);
	endtask : wr_race

	// Master ends the read with a NACK after one byte
	task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
		logic r;
		cond(1'b1, 1'b0);
		byte_tx({rei_pkg::I2C_ADDR, 1'b0}, 1'b0);
		byte_tx(ofs, 1'b0);
		cond(1'b1, 1'b0);
		byte_tx({rei_pkg::I2C_ADDR, 1'b1}, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(1'b1, r);
		cond(1'b0, 1'b1);
	endtask : reg_rd

	task automatic pulse(input logic [11:0] v);
		evt <= rei_pkg::rei_evt_t'(v);
		@(posedge i_ref_clk);
		evt <= '0;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		chk_vec("flags", 12'h000, o_flags);
		chk_bit("irq", 1'b0, o_first_irq_output);
		chk_bit("sda_oe_n", 1'b1, o_sda_oe_n);
		chk_bit("sda_out", 1'b0, o_sda_out);
	endtask : t_reset

	// Disabled clock enable must not latch anything, even later
	task automatic t_ce();
		i_ce <= 1'b0;
		pulse(12'hFFF);
		cyc(2);
		i_ce <= 1'b1;
		cyc(3);
		chk_vec("flags", 12'h000, o_flags);
	endtask : t_ce

	// One event pulse, then its flag must be latched
	task automatic ev_one(input int k);
		pulse(12'h001 << k);
		cyc(2);
		exp_f = exp_f | flag_of(k);
		chk_vec("flags", exp_f, o_flags);
	endtask : ev_one

	task automatic t_events();
		ev_one(11);
		ev_one(10);
		ev_one(9);
		ev_one(8);
		ev_one(7);
		ev_one(6);
		ev_one(5);
		ev_one(4);
		ev_one(3);
		ev_one(2);
		ev_one(1);
		ev_one(0);
		cyc(30);
		chk_vec("flags", 12'hFFF, o_flags);
		chk_bit("irq", 1'b0, o_first_irq_output);
	endtask : t_events

	// Readback, writes to read-only status, foreign address ignored
	task automatic t_regs();
		reg_rd(rei_pkg::OFS_STATUS_TWO, rd);
		chk_vec("status_two", 12'h00F, {4'h0, rd});
		reg_rd(rei_pkg::OFS_STATUS_THREE, rd);
		chk_vec("status_three", 12'h0FF, {4'h0, rd});
		// All ones, so a write taken as a clear would show
		reg_wr(rei_pkg::OFS_STATUS_TWO, 8'hFF);
		reg_wr(rei_pkg::OFS_STATUS_THREE, 8'hFF);
		cyc(3);
		chk_vec("flags", 12'hFFF, o_flags);
		cond(1'b1, 1'b0);
		byte_tx({rei_pkg::I2C_ADDR ^ 7'h01, 1'b0}, 1'b1);
		cond(1'b0, 1'b1);
	endtask : t_regs

	task automatic t_mask_clear();
		reg_wr(rei_pkg::OFS_MASK_TWO, 8'h01);
		cyc(3);
		chk_bit("irq", 1'b1, o_first_irq_output);
		reg_wr(rei_pkg::OFS_CLEAR_TWO, 8'h01);
		cyc(3);
		chk_vec("flags", 12'hFFE, o_flags);
		// Other flags still set but masked off, so the output must drop
		chk_bit("irq", 1'b0, o_first_irq_output);
		reg_wr(rei_pkg::OFS_MASK_THREE, 8'h80);
		cyc(3);
		chk_bit("irq", 1'b1, o_first_irq_output);
		reg_rd(rei_pkg::OFS_MASK_THREE, rd);
		chk_vec("mask_three", 12'h080, {4'h0, rd});
		// Event lands exactly in the clear cycle and must win
		wr_race(rei_pkg::OFS_CLEAR_THREE, 8'h80, 12'h080);
		cyc(3);
		chk_vec("flags", 12'hFFE, o_flags);
		chk_bit("irq", 1'b1, o_first_irq_output);
		reg_wr(rei_pkg::OFS_CLEAR_THREE, 8'hFF);
		cyc(3);
		chk_vec("flags", 12'h00E, o_flags);
		chk_bit("irq", 1'b0, o_first_irq_output);
		reg_wr(rei_pkg::OFS_CLEAR_TWO, 8'h0F);
		cyc(3);
		chk_vec("flags", 12'h000, o_flags);
	endtask : t_mask_clear

	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for ten cycles, then the scenarios
	initial begin
		cyc(10);
		i_nrst <= 1'b1;
		cyc(2);
		t_reset();
		t_ce();
		t_events();
		t_regs();
		t_mask_clear();
		test_done();
	end

	// Watchdog: the scenarios need a few thousand cycles at most
	initial begin
		cyc(20000);
		error_cnt++;
		test_done();
	end
endmodule : tb
